// ### rtl/kbd_link_if.sv
/*
 * the three wires between keyboard and terminal processor.
 * assumes the bench or a top joins the two modports; no clock crosses here.
 */
interface kbd_link_if;
   logic key_ready_n;
   logic host_ack_in;
   logic key_serial_data;

   modport keyboard (
      output key_ready_n,
      output key_serial_data,
      input  host_ack_in
   );
   modport processor (
      input  key_ready_n,
      input  key_serial_data,
      output host_ack_in
   );
endinterface : kbd_link_if

// ### rtl/kbd_link_keyboard.sv
/*
 * keyboard end: queues key events and sends each one as a 9-bit handshaked
 * word over the link.
 * assumes its own 10 MHz clk and reset_n; the ack line is asynchronous.
 */
// Behaviour
// - ready low starts every bit, stop included
// - ready returns high after ack falls
// - data changes after ack rises, before ready
// - stop bit low, then high, then idle
// - nine bits, byte LSB first, then stop
// - byte MSB key status, low seven key
// - stop low until ack falls, then high
// - each queued event announced by ready falling
// - processor treats ready falling as event request
// - no ack within 250 ms restarts word
// - processor acks each ready within 250 ms
// - next ready within 1 ms of ack rising
// - FE overflow, FF dead keyboard reserved
module kbd_link_keyboard #(
   parameter int unsigned ACK_TIMEOUT = kbd_link_pkg::ACK_TIMEOUT_CYC
) (
   input  wire logic                                  clk,
   input  wire logic                                  reset_n,
   input  wire logic                                  key_event_valid,
   input  wire logic                                  key_event_closed,
   input  wire logic [kbd_link_pkg::KEY_NUM_BITS-1:0] key_event_number,
   input  wire logic                                  key_dead,
   output logic                                       key_event_ready,
   output logic                                       queue_overflowed,
   kbd_link_if.keyboard                               link
);
   import kbd_link_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_READY_LOW, ST_WAIT_ACK_HIGH, ST_STOP_LOW, ST_STOP_WAIT_HIGH
   } kb_state_t;

   kb_state_t               state_q;
   logic [1:0]              ack_sync_q;
   logic                    ack_prev_q;
   logic                    ack_fall;
   logic                    ack_rise;
   logic [DATA_BITS-1:0]    queue_q [QUEUE_DEPTH];
   logic [QUEUE_PTR_W-1:0]  wr_ptr_q;
   logic [QUEUE_PTR_W-1:0]  rd_ptr_q;
   logic [QUEUE_PTR_W:0]    count_q;
   logic                    overflow_pending_q;
   logic                    push;
   logic                    pop;
   logic [DATA_BITS-1:0]    word_q;
   logic [BIT_IDX_W-1:0]    bit_idx_q;
   logic [TIMER_W-1:0]      timer_q;
   logic                    ready_n_q;
   logic                    data_q;
   logic                    word_loaded;

   // two flops before edge detection, ack comes from another clock
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_sync_q <= 2'h3;
         ack_prev_q <= 1'b1;
      end else begin
         ack_sync_q <= {ack_sync_q[0], link.host_ack_in};
         ack_prev_q <= ack_sync_q[1];
      end
   end
   assign ack_fall = ack_prev_q & ~ack_sync_q[1];
   assign ack_rise = ~ack_prev_q & ack_sync_q[1];

   // one slot is kept back so the overflow code always has a place
   assign key_event_ready = (count_q < (QUEUE_PTR_W+1)'(QUEUE_DEPTH - 1)) && !overflow_pending_q;
   assign push = key_event_valid && key_event_ready;
   assign queue_overflowed = overflow_pending_q;
   assign word_loaded = (state_q == ST_IDLE) && (count_q != '0 || key_dead);
   assign pop = word_loaded && !key_dead;

   // event queue, status in MSB and key number below
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_q           <= '0;
         rd_ptr_q           <= '0;
         count_q            <= '0;
         overflow_pending_q <= 1'b0;
      end else begin
         if (push) begin
            queue_q[wr_ptr_q] <= {key_event_closed, key_event_number};
            wr_ptr_q          <= wr_ptr_q + 1'b1;
         end else if (overflow_pending_q && count_q < (QUEUE_PTR_W+1)'(QUEUE_DEPTH)) begin
            queue_q[wr_ptr_q]  <= CODE_OVERFLOW;
            wr_ptr_q           <= wr_ptr_q + 1'b1;
            overflow_pending_q <= 1'b0;
         end
         if (key_event_valid && !key_event_ready && !overflow_pending_q) begin
            overflow_pending_q <= 1'b1;                            // key lost
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         count_q <= count_q
                    + (QUEUE_PTR_W+1)'(push || (overflow_pending_q && !push
                                              && count_q < (QUEUE_PTR_W+1)'(QUEUE_DEPTH)))
                    - (QUEUE_PTR_W+1)'(pop);
      end
   end

   // word transmit state machine
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q   <= ST_IDLE;
         ready_n_q <= 1'b1;
         data_q    <= 1'b1;
         word_q    <= '0;
         bit_idx_q <= '0;
         timer_q   <= '0;
      end else begin
         timer_q <= timer_q + 1'b1;
         unique case (state_q)
            ST_IDLE: begin
               if (word_loaded) begin
                  // dead keyboard reports FF instead of queue contents
                  word_q    <= key_dead ? CODE_DEAD : queue_q[rd_ptr_q];
                  data_q    <= key_dead ? CODE_DEAD[0] : queue_q[rd_ptr_q][0]; // LSB first
                  bit_idx_q <= '0;
                  timer_q   <= '0;
                  state_q   <= ST_READY_LOW;
               end
            end
            ST_READY_LOW: begin
               // data settled the cycle before ready drops
               ready_n_q <= 1'b0;
               if (ready_n_q) begin
                  timer_q <= '0;
               end else if (ack_fall) begin
                  ready_n_q <= 1'b1;
                  state_q   <= ST_WAIT_ACK_HIGH;
               end else if (timer_q >= TIMER_W'(ACK_TIMEOUT - 1)) begin
                  // give up and resend from bit 0
                  ready_n_q <= 1'b1;
                  bit_idx_q <= '0;
                  data_q    <= word_q[0];
                  state_q   <= ST_WAIT_ACK_HIGH;
               end
            end
            ST_WAIT_ACK_HIGH: begin
               // after a timeout ack is already high, so move straight on
               if (ack_rise || (bit_idx_q == '0 && ack_sync_q[1] && ready_n_q && data_q == word_q[0]
                                && timer_q >= TIMER_W'(ACK_TIMEOUT - 1))) begin
                  if (bit_idx_q == LAST_DATA_IDX) begin
                     data_q  <= 1'b0;                              // stop bit low
                     state_q <= ST_STOP_LOW;
                  end else begin
                     bit_idx_q <= ack_rise ? bit_idx_q + 1'b1 : bit_idx_q;
                     data_q    <= ack_rise ? word_q[3'(bit_idx_q + 1'b1)] : word_q[0];
                     state_q   <= ST_READY_LOW;                    // next ready in a cycle
                  end
                  timer_q <= '0;
               end
            end
            ST_STOP_LOW: begin
               ready_n_q <= 1'b0;
               if (ready_n_q) begin
                  timer_q <= '0;
               end else if (ack_fall) begin
                  data_q    <= 1'b1;
                  ready_n_q <= 1'b1;
                  state_q   <= ST_STOP_WAIT_HIGH;
               end else if (timer_q >= TIMER_W'(ACK_TIMEOUT - 1)) begin
                  ready_n_q <= 1'b1;
                  bit_idx_q <= '0;
                  data_q    <= word_q[0];
                  state_q   <= ST_WAIT_ACK_HIGH;
               end
            end
            ST_STOP_WAIT_HIGH: begin
               if (ack_rise) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   assign link.key_ready_n     = ready_n_q;
   assign link.key_serial_data = data_q;
endmodule : kbd_link_keyboard

// ### rtl/kbd_link_pkg.sv
/*
 * constants shared by both ends of the keyboard handshake link: word layout,
 * reserved codes and handshake timing.
 * assumes a 10 MHz clk on each side; the link itself carries no clock.
 */
package kbd_link_pkg;
   localparam int unsigned CLK_HZ           = 10_000_000;
   localparam int unsigned WORD_BITS        = 9;
   localparam int unsigned DATA_BITS        = 8;
   localparam int unsigned BIT_IDX_W        = 4;
   localparam int unsigned KEY_NUM_BITS     = 7;
   localparam int unsigned STATUS_BIT       = 7;
   localparam logic [7:0]  CODE_OVERFLOW    = 8'hFE;
   localparam logic [7:0]  CODE_DEAD        = 8'hFF;
   localparam int unsigned QUEUE_DEPTH      = 8;
   localparam int unsigned QUEUE_PTR_W      = 3;
   // handshake timing in its own units
   localparam int unsigned READY_LOW_TO_ACK_LOW_TIME_MS  = 250;
   localparam int unsigned ACK_HIGH_TO_READY_LOW_TIME_MS = 1;
   // longest waits round down to whole cycles
   localparam int unsigned ACK_TIMEOUT_CYC =
      READY_LOW_TO_ACK_LOW_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned READY_DELAY_MAX_CYC =
      ACK_HIGH_TO_READY_LOW_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned TIMER_W          = 22;
   localparam logic [BIT_IDX_W-1:0] LAST_DATA_IDX = 4'h7;
endpackage : kbd_link_pkg

// ### rtl/kbd_link_processor.sv
/*
 * terminal processor end: acknowledges each bit, assembles the byte and
 * hands it to the user side.
 * assumes its own 10 MHz clk and reset_n; ready and data are asynchronous.
 */
module kbd_link_processor (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   output logic                               word_valid,
   output logic [kbd_link_pkg::DATA_BITS-1:0] word_data,
   output logic                               word_overflow,
   output logic                               word_dead,
   output logic                               event_request,
   kbd_link_if.processor                      link
);
   import kbd_link_pkg::*;

   logic [1:0]            rdy_sync_q;
   logic [1:0]            dat_sync_q;
   logic                  rdy_prev_q;
   logic                  ack_q;
   logic [BIT_IDX_W-1:0]  bit_idx_q;
   logic [DATA_BITS-1:0]  shift_q;
   logic                  valid_q;
   logic [DATA_BITS-1:0]  data_q;
   logic                  rdy_fall;

   // synchronise ready and data before use
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdy_sync_q <= 2'h3;
         dat_sync_q <= 2'h3;
         rdy_prev_q <= 1'b1;
      end else begin
         rdy_sync_q <= {rdy_sync_q[0], link.key_ready_n};
         dat_sync_q <= {dat_sync_q[0], link.key_serial_data};
         rdy_prev_q <= rdy_sync_q[1];
      end
   end
   assign rdy_fall = rdy_prev_q & ~rdy_sync_q[1];

   // ack falls on each ready low, well within the timeout; rises once
   // ready is back high, releasing the next bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q     <= 1'b1;
         bit_idx_q <= '0;
         shift_q   <= '0;
         valid_q   <= 1'b0;
         data_q    <= '0;
      end else begin
         valid_q <= 1'b0;
         if (rdy_fall) begin
            ack_q <= 1'b0;
            if (bit_idx_q < BIT_IDX_W'(DATA_BITS)) begin
               shift_q   <= {dat_sync_q[1], shift_q[DATA_BITS-1:1]}; // LSB first
               bit_idx_q <= bit_idx_q + 1'b1;
            end else begin
               // stop bit; byte complete
               data_q    <= shift_q;
               valid_q   <= 1'b1;
               bit_idx_q <= '0;
            end
         end else if (!ack_q && rdy_sync_q[1]) begin
            ack_q <= 1'b1;
         end
      end
   end

   // a ready left low without ack past the timeout means the keyboard restarted the word;
   // this end never lets the timeout run, so the count only resets on stop
   assign event_request = rdy_fall;
   assign word_valid    = valid_q;
   assign word_data     = data_q;
   assign word_overflow = valid_q && data_q == CODE_OVERFLOW;
   assign word_dead     = valid_q && data_q == CODE_DEAD;
   assign link.host_ack_in = ack_q;
endmodule : kbd_link_processor

// ### verification/kbd_link_assertions.sv
/*
 * link checker: handshake and framing properties on the three link wires.
 * assumes both ends share clk and reset_n; instantiated beside the interface.
 */
module kbd_link_assertions (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic key_ready_n,
   input wire logic host_ack_in,
   input wire logic key_serial_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       ack_q;
   logic [3:0] bit_q; // bits finished in the current word

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // count ack rises so the stop bit is known without peeking inside either end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b1;
         bit_q <= 4'h0;
      end else begin
         ack_q <= host_ack_in;
         if (host_ack_in && !ack_q) bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      end
   end

   a_ready_after_ack: assert property ($fell(host_ack_in) |-> ##[1:6] key_ready_n)
      else $error("ready stayed low after ack fell");
   a_ready_held_low: assert property ($rose(key_ready_n) |-> !host_ack_in)
      else $error("ready rose before ack fell");
   a_data_stable_low: assert property (!key_ready_n |-> $stable(key_serial_data))
      else $error("data moved while ready low");
   a_data_moves_late: assert property ($changed(key_serial_data) && !$rose(key_ready_n)
      |-> key_ready_n && host_ack_in)
      else $error("data moved outside ack high");
   a_stop_bit_low: assert property (!key_ready_n && bit_q == 4'h8 |-> !key_serial_data)
      else $error("stop bit not low");
   a_stop_goes_high: assert property ($rose(key_ready_n) && bit_q == 4'h8 |-> key_serial_data)
      else $error("stop bit not high at ready rise");
   a_idle_after_stop: assert property ($rose(host_ack_in) && bit_q == 4'h8
      |-> key_ready_n && key_serial_data)
      else $error("link not idle after stop");
   a_next_bit_ready: assert property ($rose(host_ack_in) && bit_q != 4'h8 |-> ##[1:1000] !key_ready_n)
      else $error("next bit ready late");
   a_ack_answers: assert property ($fell(key_ready_n) |-> ##[1:8] !host_ack_in)
      else $error("ack did not fall");
   a_ack_release: assert property ($rose(key_ready_n) |-> ##[1:8] host_ack_in)
      else $error("ack did not rise");

   c_stop_bit: cover property (!key_ready_n && bit_q == 4'h8);
   c_ack_fall: cover property ($fell(host_ack_in));
   c_word_end: cover property ($rose(host_ack_in) && bit_q == 4'h8);
endmodule : kbd_link_assertions

// ### verification/tb_top.sv
/*
 * bench top: both link ends back to back, plus a lone keyboard end whose ack
 * the bench drives to force the timeout.
 * assumes one 10 MHz clock for every end.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import kbd_link_pkg::*;
   localparam int unsigned TMO = 200; // shortened ack timeout
   logic clk = 1'b0, reset_n = 1'b0, ev_valid = 1'b0, ev_closed = 1'b0, dead = 1'b0, f_valid = 1'b0;
   logic [KEY_NUM_BITS-1:0] ev_num = '0;
   logic                    ev_ready, ovf, w_valid, w_ovf, w_dead, ev_req, f_ready;
   logic [DATA_BITS-1:0]    w_data;
   logic [7:0]              lfsr_q = 8'h61; // seed 97
   logic [7:0]              exp_q[$];
   int                      mismatches = 0, check_count = 0, words = 0, reqs = 0, dead_mode = 0;
   kbd_link_if link ();
   kbd_link_if flink ();
   kbd_link_keyboard #(.ACK_TIMEOUT(TMO)) kbd_link_keyboard_inst (.clk(clk), .reset_n(reset_n),
      .key_event_valid(ev_valid), .key_event_closed(ev_closed), .key_event_number(ev_num), .key_dead(dead),
      .key_event_ready(ev_ready), .queue_overflowed(ovf), .link(link.keyboard));
   kbd_link_processor kbd_link_processor_inst (.clk(clk), .reset_n(reset_n), .word_valid(w_valid),
      .word_data(w_data), .word_overflow(w_ovf), .word_dead(w_dead), .event_request(ev_req),
      .link(link.processor));
   kbd_link_keyboard #(.ACK_TIMEOUT(TMO)) kbd_link_keyboard_inst_b (.clk(clk), .reset_n(reset_n),
      .key_event_valid(f_valid), .key_event_closed(ev_closed), .key_event_number(ev_num), .key_dead(1'b0),
      .key_event_ready(f_ready), .queue_overflowed(), .link(flink.keyboard));
   kbd_link_assertions kbd_link_assertions_inst (.clk(clk), .reset_n(reset_n), .key_ready_n(link.key_ready_n),
      .host_ack_in(link.host_ack_in), .key_serial_data(link.key_serial_data));

   always #50 clk = ~clk;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // a wait that runs out is scored and ends the run
   task automatic step(inout int n);
      @(posedge clk);
      #10;
      n++;
      if (n > 20000) begin
         mismatches++;
         $display("mismatch wait expected done seen timeout");
         end_of_test();
      end
   endtask : step

   // valid drops only while waiting, so a refused offer is never made by accident
   task automatic offer(input logic c, input logic [6:0] k);
      int n = 0;
      while (ev_ready !== 1'b1) begin ev_valid = 1'b0; step(n); end
      ev_closed = c; ev_num = k; ev_valid = 1'b1;
      exp_q.push_back({c, k});
      @(posedge clk);
      #10;
   endtask : offer

   // idle means ready high for longer than any gap between bits
   task automatic drain();
      int n = 0, q = 0;
      while (exp_q.size() != 0) step(n);
      while (q < 30) begin step(n); q = (link.key_ready_n === 1'b1) ? q + 1 : 0; end
   endtask : drain

   task automatic wait_f(input logic lvl, inout int n);
      while (flink.key_ready_n !== lvl) step(n);
   endtask : wait_f

   // score words at the falling edge, where the outputs have settled
   always @(negedge clk) begin
      if (ev_req === 1'b1) reqs++;
      if (w_valid === 1'b1) begin
         words++;
         if (dead_mode != 0) check("dead_word", {w_dead, w_data[6:0]}, CODE_DEAD);
         else if (exp_q.size() == 0) check("spare_word", 8'(w_valid), 8'h00);
         else begin
            check("word_data", w_data, exp_q[0]);
            check("ovf_flag", 8'(w_ovf), 8'(exp_q[0] == CODE_OVERFLOW));
            check("dead_flag", 8'(w_dead), 8'(exp_q[0] == CODE_DEAD));
            void'(exp_q.pop_front());
         end
      end
   end

   initial begin
      int n, w0;
      logic pend;
      flink.host_ack_in = 1'b1;
      repeat (4) @(posedge clk);
      #10 reset_n = 1'b1;
      offer(1'b1, 7'h00);
      offer(1'b0, 7'h7F);
      for (int i = 0; i < 10; i++) begin lfsr_q = lfsr(lfsr_q); offer(lfsr_q[7], lfsr_q[6:0]); end
      ev_valid = 1'b0;
      drain();
      $display("test random done");
      // nine offers from an empty queue: eight fit, the ninth is lost and one lost code follows;
      // a longer burst would lose keys again once the code fills the spare slot
      pend = 1'b0;
      for (int i = 0; i < 9; i++) begin
         lfsr_q = lfsr(lfsr_q);
         ev_closed = lfsr_q[7]; ev_num = lfsr_q[6:0]; ev_valid = 1'b1;
         if (ev_ready === 1'b1) exp_q.push_back(lfsr_q);
         else pend = 1'b1;
         @(posedge clk);
         #10;
      end
      ev_valid = 1'b0;
      check("lost_flag", 8'(ovf), 8'h01);
      check("refusal", 8'(pend), 8'h01);
      n = 0;
      while (ovf !== 1'b0) step(n);
      exp_q.push_back(CODE_OVERFLOW);
      drain();
      $display("test overflow done");
      dead_mode = 1; dead = 1'b1; n = 0; w0 = words;
      while (words < w0 + 2) step(n);
      dead = 1'b0;
      drain();
      dead_mode = 0;
      $display("test dead done");
      check("f_ready", 8'(f_ready), 8'h01);
      ev_num = 7'h01; ev_closed = 1'b0; f_valid = 1'b1;
      @(posedge clk);
      #10 f_valid = 1'b0;
      n = 0;
      wait_f(1'b0, n);
      check("bit0", 8'(flink.key_serial_data), 8'h01);
      flink.host_ack_in = 1'b0;
      wait_f(1'b1, n);
      flink.host_ack_in = 1'b1;
      wait_f(1'b0, n);
      check("bit1", 8'(flink.key_serial_data), 8'h00);
      n = 0;
      wait_f(1'b1, n);
      check("timeout", 8'(n >= TMO - 1 && n <= TMO + 2), 8'h01);
      wait_f(1'b0, n);
      check("restart", 8'(flink.key_serial_data), 8'h01);
      $display("test timeout done");
      check("requests", 8'(reqs == WORD_BITS * words), 8'h01);
      end_of_test();
   end
endmodule : tb_top
